// >>> logic/sdc_host.sv
`timescale 1ns/1ps
module sdc_host
  import sdc_pkg::*;
#(
  parameter int NUM_DEV = 1
) (
  // Clock and reset
  input  wire logic                       CLK,
  input  wire logic                       RESET_N,
  // Word stream, farthest converter first
  input  wire logic                       IN_VALID,
  input  wire logic [sdc_pkg::WORD_W-1:0] IN_DATA,
  output logic                            IN_READY,
  // Commands
  input  wire logic                       FRAME_START,
  input  wire logic                       CLEAR_START,
  input  wire logic                       TWOS_COMP,
  input  wire logic [1:0]                 CAL_MODE,
  // Status and read-back from the chain tail
  output logic                            BUSY,
  output logic                            RB_VALID,
  output logic [sdc_pkg::WORD_W-1:0]      RB_DATA,
  // Converter pins
  output logic                            SHIFT_STROBE_A,
  output logic                            SHIFT_STROBE_B,
  output logic                            SHIFT_STROBE_C,
  output logic                            SHIFT_STROBE_FALL_N,
  output logic                            SERIAL_IN,
  output logic                            TRANSFER_N_A,
  output logic                            TRANSFER_N_B,
  output logic                            DAC_REG_ZERO_N,
  input  wire logic                       SERIAL_CHAIN_OUT
);

  import sdc_pkg::*;

  localparam int BW = 4;
  localparam int DW = $clog2(NUM_DEV + 1);
  localparam int CW = 8;

  // ==========================================================
  // Declarations
  sdc_state_t        state_r;
  sdc_state_t        state_nxt;
  logic [WORD_W-1:0] shift_r;
  logic [WORD_W-1:0] shift_nxt;
  logic [WORD_W-1:0] rb_sh_r;
  logic [WORD_W-1:0] rb_sh_nxt;
  logic [WORD_W-1:0] rb_data_r;
  logic [WORD_W-1:0] rb_data_nxt;
  logic              rb_valid_r;
  logic              rb_valid_nxt;
  logic [BW-1:0]     bit_r;
  logic [BW-1:0]     bit_nxt;
  logic [DW-1:0]     dev_r;
  logic [DW-1:0]     dev_nxt;
  logic [CW-1:0]     cnt_r;
  logic [CW-1:0]     cnt_nxt;
  logic [1:0]        cal_r;
  logic [1:0]        cal_nxt;
  logic              tc_r;
  logic              tc_nxt;
  logic              strobe_r;
  logic              strobe_nxt;
  logic              serial_r;
  logic              serial_nxt;
  logic              xfer_n_r;
  logic              xfer_n_nxt;
  logic              zero_n_r;
  logic              zero_n_nxt;
  logic              busy_r;
  logic              busy_nxt;
  logic              sro_s1_r;
  logic              sro_s2_r;
  logic              fifo_valid;
  logic [WORD_W-1:0] fifo_data;
  logic              fifo_pop;
  logic              restart;
  logic              tick;
  logic              go;
  logic [WORD_W-1:0] word;

  // ==========================================================
  // Word buffer; while empty it stalls data frames, calibration frames never wait
  sdc_fifo #(
    .W     (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst_n     (RESET_N),
    .in_valid  (IN_VALID),
    .in_data   (IN_DATA),
    .in_ready  (IN_READY),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_pop)
  );

  // ==========================================================
  // Strobe half-period enable
  sdc_tick #(
    .HALF (STB_HALF_CYC)
  ) u_tick (
    .clk     (CLK),
    .rst_n   (RESET_N),
    .restart (restart),
    .tick    (tick)
  );

  // ==========================================================
  // Chain tail input synchroniser
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sro_s1_r <= 1'b0;
      sro_s2_r <= 1'b0;
    end else begin
      sro_s1_r <= SERIAL_CHAIN_OUT;
      sro_s2_r <= sro_s1_r;
    end
  end

  // ==========================================================
  // Sequencer
  always_comb begin
    state_nxt    = state_r;
    shift_nxt    = shift_r;
    rb_sh_nxt    = rb_sh_r;
    rb_data_nxt  = rb_data_r;
    rb_valid_nxt = 1'b0;
    bit_nxt      = bit_r;
    dev_nxt      = dev_r;
    cnt_nxt      = cnt_r;
    cal_nxt      = cal_r;
    tc_nxt       = tc_r;
    strobe_nxt   = strobe_r;
    serial_nxt   = serial_r;
    xfer_n_nxt   = xfer_n_r;
    zero_n_nxt   = zero_n_r;
    fifo_pop     = 1'b0;
    restart      = 1'b0;
    go           = 1'b0;
    word         = fifo_data;
    case (state_r)
      ST_IDLE: begin
        // Clear wins over a frame requested in the same cycle
        if (CLEAR_START) begin
          zero_n_nxt = 1'b0;
          cnt_nxt    = CW'(CLEAR_CYC - 1);
          state_nxt  = ST_CLEAR;
        end else if (FRAME_START) begin
          cal_nxt   = CAL_MODE;
          tc_nxt    = TWOS_COMP;
          dev_nxt   = '0;
          state_nxt = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // Calibration codes need no buffered words
        restart = 1'b1;
        if (cal_r == CAL_MID) begin
          word = MID_SCALE;
          go   = 1'b1;
        end else if (cal_r == CAL_FULL) begin
          word = FULL_SCALE;
          go   = 1'b1;
        end else if (fifo_valid) begin
          // Offset binary from two's complement
          word     = fifo_data ^ {tc_r, {(WORD_W-1){1'b0}}};
          fifo_pop = 1'b1;
          go       = 1'b1;
        end
        if (go) begin
          // Right-justified word, top bit goes out first
          shift_nxt  = word;
          serial_nxt = word[WORD_W-1];
          bit_nxt    = '0;
          state_nxt  = ST_LOW;
        end
      end
      ST_LOW: begin
        // Data has had a half period of setup before the rise
        if (tick) begin
          strobe_nxt = 1'b1;
          state_nxt  = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (tick) begin
          strobe_nxt = 1'b0;
          shift_nxt  = shift_r << 1;
          // Tail bit sampled late in the high phase, long after it moved
          rb_sh_nxt  = {rb_sh_r[WORD_W-2:0], sro_s2_r};
          if (bit_r == BW'(WORD_W - 1)) begin
            rb_valid_nxt = 1'b1;
            rb_data_nxt  = {rb_sh_r[WORD_W-2:0], sro_s2_r};
            if (dev_r == DW'(NUM_DEV - 1)) begin
              // Shared load only after all 12N edges
              xfer_n_nxt = 1'b0;
              cnt_nxt    = CW'(LOAD_CYC - 1);
              state_nxt  = ST_LOAD;
            end else begin
              dev_nxt   = dev_r + 1'b1;
              state_nxt = ST_FETCH;
            end
          end else begin
            // Next bit presented on the falling edge
            bit_nxt    = bit_r + 1'b1;
            serial_nxt = shift_r[WORD_W-2];
            state_nxt  = ST_LOW;
          end
        end
      end
      ST_LOAD: begin
        if (cnt_r == '0) begin
          xfer_n_nxt = 1'b1;
          state_nxt  = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      ST_CLEAR: begin
        if (cnt_r == '0) begin
          zero_n_nxt = 1'b1;
          state_nxt  = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: begin
        state_nxt  = ST_IDLE;
        strobe_nxt = 1'b0;
        xfer_n_nxt = 1'b1;
        zero_n_nxt = 1'b1;
      end
    endcase
    busy_nxt = (state_nxt != ST_IDLE);
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r    <= ST_IDLE;
      shift_r    <= ZERO_CODE;
      rb_sh_r    <= ZERO_CODE;
      rb_data_r  <= ZERO_CODE;
      rb_valid_r <= 1'b0;
      bit_r      <= '0;
      dev_r      <= '0;
      cnt_r      <= '0;
      cal_r      <= CAL_OFF;
      tc_r       <= 1'b0;
      strobe_r   <= 1'b0;
      serial_r   <= 1'b0;
      xfer_n_r   <= 1'b1;
      zero_n_r   <= 1'b1;
      busy_r     <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      shift_r    <= shift_nxt;
      rb_sh_r    <= rb_sh_nxt;
      rb_data_r  <= rb_data_nxt;
      rb_valid_r <= rb_valid_nxt;
      bit_r      <= bit_nxt;
      dev_r      <= dev_nxt;
      cnt_r      <= cnt_nxt;
      cal_r      <= cal_nxt;
      tc_r       <= tc_nxt;
      strobe_r   <= strobe_nxt;
      serial_r   <= serial_nxt;
      xfer_n_r   <= xfer_n_nxt;
      zero_n_r   <= zero_n_nxt;
      busy_r     <= busy_nxt;
    end
  end

  // ==========================================================
  // Pin drive; unused strobes parked at non-blocking levels
  always_comb begin
    SHIFT_STROBE_A      = strobe_r;
    SHIFT_STROBE_B      = 1'b0;
    SHIFT_STROBE_C      = 1'b0;
    SHIFT_STROBE_FALL_N = 1'b1;
    SERIAL_IN           = serial_r;
    // Both loads move together, never while clearing
    TRANSFER_N_A        = xfer_n_r;
    TRANSFER_N_B        = xfer_n_r;
    DAC_REG_ZERO_N      = zero_n_r;
    BUSY                = busy_r;
    RB_VALID            = rb_valid_r;
    RB_DATA             = rb_data_r;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  int hi_cnt;
  int edge_cnt;
  int zero_cnt;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hi_cnt   <= 0;
      edge_cnt <= 0;
      zero_cnt <= 0;
    end else begin
      hi_cnt   <= strobe_r ? hi_cnt + 1 : 0;
      zero_cnt <= !zero_n_r ? zero_cnt + 1 : 0;
      if (state_r == ST_IDLE) begin
        edge_cnt <= 0;
      end else if (strobe_nxt && !strobe_r) begin
        edge_cnt <= edge_cnt + 1;
      end
    end
  end

  park_levels_a: assert property (
    !SHIFT_STROBE_B && !SHIFT_STROBE_C && SHIFT_STROBE_FALL_N)
    else $error("Unused strobe left its parked level");

  load_pair_a: assert property (
    TRANSFER_N_A == TRANSFER_N_B)
    else $error("Load pins differ");

  strobe_width_a: assert property (
    $fell(SHIFT_STROBE_A) |-> hi_cnt == STB_HALF_CYC)
    else $error("Strobe high phase has wrong length");

  data_hold_a: assert property (
    SHIFT_STROBE_A && $past(SHIFT_STROBE_A) |-> $stable(SERIAL_IN))
    else $error("Serial data moved while strobe high");

  msb_first_a: assert property (
    state_r == ST_LOW && $past(state_r) == ST_FETCH
      |-> SERIAL_IN == shift_r[WORD_W-1] && bit_r == '0)
    else $error("Word does not start with its top bit");

  frame_edges_a: assert property (
    $fell(TRANSFER_N_A) |-> edge_cnt == WORD_W * NUM_DEV)
    else $error("Load issued after wrong number of edges");

  load_quiet_a: assert property (
    !TRANSFER_N_A |-> !SHIFT_STROBE_A && DAC_REG_ZERO_N)
    else $error("Load overlaps strobe or clear");

  clear_width_a: assert property (
    $rose(DAC_REG_ZERO_N) |-> zero_cnt == CLEAR_CYC)
    else $error("Clear pulse has wrong length");

  cal_code_a: assert property (
    state_r == ST_LOW && $past(state_r) == ST_FETCH && cal_r == CAL_FULL
      |-> shift_r == FULL_SCALE)
    else $error("Full-scale calibration code not sent");

endmodule : sdc_host

// >>> inc/sdc_pkg.sv
// Functional notes
// - Serial bits enter MSB first, one bit per active strobe edge.
// - Chained converters share strobe and load lines; tail feeds next.
// - Each strobing write presents exactly the next serial bit.
// - Serial bit comes from the top bit of the host word.
// - Word held as upper nibble plus lower byte, upper part first.
// - Host makes a rising-edge strobe per write.
// - Second write asserts both load inputs to transfer the word.
// - Host serial pin supplies data while writes make strobes.
// - Strobe comes from an address decode qualified by write strobe.
// - Word held right-justified, shifted out upper bits first.
// - Two's complement becomes offset binary by inverting the MSB.
// - Calibration loads mid-scale for zero, all ones for full scale.
package sdc_pkg;

  // ==========================================================
  // Word format
  localparam int          WORD_W      = 12;
  localparam int          FIFO_DEPTH  = 8;
  localparam logic [11:0] ZERO_CODE   = 12'h000;
  localparam logic [11:0] MID_SCALE   = 12'h800;
  localparam logic [11:0] FULL_SCALE  = 12'hfff;

  // ==========================================================
  // Calibration modes
  localparam logic [1:0]  CAL_OFF     = 2'h0;
  localparam logic [1:0]  CAL_MID     = 2'h1;
  localparam logic [1:0]  CAL_FULL    = 2'h2;

  // ==========================================================
  // Timing
  localparam int          CLK_MHZ     = 200;
  localparam int          STB_HALF_NS = 40;
  localparam int          STB_HALF_CYC =
    (STB_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int          LOAD_NS     = 50;
  localparam int          LOAD_CYC    = (LOAD_NS * CLK_MHZ + 999) / 1000;
  localparam int          CLEAR_NS    = 50;
  localparam int          CLEAR_CYC   = (CLEAR_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_LOW   = 3'b010,
    ST_HIGH  = 3'b011,
    ST_LOAD  = 3'b100,
    ST_CLEAR = 3'b101
  } sdc_state_t;

endpackage : sdc_pkg

// >>> logic/sdc_fifo.sv
`timescale 1ns/1ps
module sdc_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] wr_nxt;
  logic [AW-1:0] rd_r;
  logic [AW-1:0] rd_nxt;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          rdy_r;
  logic          rdy_nxt;
  logic          push;
  logic          pop;

  // ==========================================================
  // Pointers and occupancy
  always_comb begin
    push    = in_valid && rdy_r;
    pop     = out_ready && (cnt_r != '0);
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wr_nxt = (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
    end
    if (pop) begin
      rd_nxt = (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
    // Ready is registered so the top port stays a flop output
    rdy_nxt = (cnt_nxt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b1;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  assign in_ready  = rdy_r;
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rd_r];

endmodule : sdc_fifo

// >>> logic/sdc_tick.sv
`timescale 1ns/1ps
module sdc_tick #(
  parameter int HALF = 8
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic restart,
  output logic      tick
);

  localparam int CW = $clog2(HALF + 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          tick_r;
  logic          tick_nxt;

  // ==========================================================
  // One-cycle enable every HALF clocks, phase set by restart
  always_comb begin
    cnt_nxt  = cnt_r + 1'b1;
    tick_nxt = 1'b0;
    if (restart) begin
      cnt_nxt = '0;
    end else if (cnt_r == CW'(HALF - 1)) begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule : sdc_tick

// >>> sim/sdc_conv_model.sv
`timescale 1ns/1ps
module sdc_conv_model
  import sdc_pkg::*;
#(
  parameter int NUM_DEV = 2
) (
  // Strobes
  input  wire logic                               shift_strobe_a,
  input  wire logic                               shift_strobe_b,
  input  wire logic                               shift_strobe_c,
  input  wire logic                               shift_strobe_fall_n,
  // Data and control
  input  wire logic                               serial_in,
  input  wire logic                               transfer_n_a,
  input  wire logic                               transfer_n_b,
  input  wire logic                               dac_reg_zero_n,
  output logic                                    serial_chain_out,
  // Observation
  output logic [NUM_DEV*sdc_pkg::WORD_W-1:0]      sr_all,
  output logic [NUM_DEV*sdc_pkg::WORD_W-1:0]      dac_all
);
  localparam int N = NUM_DEV * WORD_W;
  logic rise_hit;
  logic fall_hit;

  // ==========================================================
  // Input shift registers of the whole chain as one long word
  // Device 0 holds the low word; each tail bit feeds the next device
  initial sr_all = '0;
  initial dac_all = '0;
  always @(posedge shift_strobe_a or posedge shift_strobe_b or
           posedge shift_strobe_c or negedge shift_strobe_fall_n) begin
    // Levels read here, not via a net that may update after this edge
    rise_hit = $onehot({shift_strobe_a, shift_strobe_b, shift_strobe_c})
               && shift_strobe_fall_n;
    fall_hit = !(shift_strobe_a | shift_strobe_b | shift_strobe_c)
               && !shift_strobe_fall_n;
    if (rise_hit || fall_hit)
      sr_all <= {sr_all[N-2:0], serial_in};
  end
  assign serial_chain_out = sr_all[N-1];

  // ==========================================================
  // Converter registers: level loads, clear wins, strobes never touch
  always @(dac_reg_zero_n or transfer_n_a or transfer_n_b or sr_all) begin
    if (!dac_reg_zero_n)
      dac_all = '0;
    else if (!transfer_n_a && !transfer_n_b)
      dac_all = sr_all;
  end
endmodule : sdc_conv_model

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import sdc_pkg::*;
  localparam int ND = 2;
  localparam int N  = ND * WORD_W;
  logic              clk, reset_n, in_valid, in_ready, frame_start;
  logic              clear_start, twos_comp, busy, rb_valid;
  logic              stb_a, stb_b, stb_c, stb_fn, ser, ld_a, ld_b;
  logic              zero_n, tail;
  logic [1:0]        cal_mode;
  logic [WORD_W-1:0] in_data, rb_data, old_far, old_near;
  logic [N-1:0]      sr_all, dac_all;
  logic [WORD_W-1:0] fifo_q[$];
  int                n_errors, compares, cycles;

  sdc_host #(.NUM_DEV(ND)) dut (
    .CLK(clk), .RESET_N(reset_n), .IN_VALID(in_valid), .IN_DATA(in_data),
    .IN_READY(in_ready), .FRAME_START(frame_start),
    .CLEAR_START(clear_start), .TWOS_COMP(twos_comp), .CAL_MODE(cal_mode),
    .BUSY(busy), .RB_VALID(rb_valid), .RB_DATA(rb_data),
    .SHIFT_STROBE_A(stb_a), .SHIFT_STROBE_B(stb_b), .SHIFT_STROBE_C(stb_c),
    .SHIFT_STROBE_FALL_N(stb_fn), .SERIAL_IN(ser), .TRANSFER_N_A(ld_a),
    .TRANSFER_N_B(ld_b), .DAC_REG_ZERO_N(zero_n), .SERIAL_CHAIN_OUT(tail));

  sdc_conv_model #(.NUM_DEV(ND)) conv (
    .shift_strobe_a(stb_a), .shift_strobe_b(stb_b), .shift_strobe_c(stb_c),
    .shift_strobe_fall_n(stb_fn), .serial_in(ser), .transfer_n_a(ld_a),
    .transfer_n_b(ld_b), .dac_reg_zero_n(zero_n), .serial_chain_out(tail),
    .sr_all(sr_all), .dac_all(dac_all));

  // ==========================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [N-1:0] seen, input logic [N-1:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic push(input logic [WORD_W-1:0] w, output logic took);
    @(negedge clk);
    in_valid = 1'b1;
    in_data  = w;
    took     = in_ready;
    @(negedge clk);
    in_valid = 1'b0;
    // Released data shows garbage, not the last word
    in_data  = ~w;
  endtask : push

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check(stb_b, 1'b0);
    check(stb_c, 1'b0);
    check(stb_fn, 1'b1);
    check({ld_a, ld_b, zero_n}, 3'b111);
    check({busy, rb_valid, stb_a, in_ready}, 4'b0001);
  endtask : t_reset

  task automatic t_fill();
    logic              took;
    logic [WORD_W-1:0] w;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      w = WORD_W'(12'h123 * (i + 1));
      push(w, took);
      check(took, 1'b1);
      fifo_q.push_back(w);
    end
    check(in_ready, 1'b0);
    push(12'h5a5, took);
    check(took, 1'b0);
  endtask : t_fill

  task automatic run_frame(input logic tc, input logic [1:0] cm);
    logic [WORD_W-1:0] far, near;
    logic [WORD_W-1:0] q[$];
    logic [N-1:0]      dac_before;
    int                k;
    case (cm)
      CAL_MID: begin
        far  = MID_SCALE;
        near = MID_SCALE;
      end
      CAL_FULL: begin
        far  = FULL_SCALE;
        near = FULL_SCALE;
      end
      default: begin
        far  = fifo_q.pop_front() ^ {tc, 11'h000};
        near = fifo_q.pop_front() ^ {tc, 11'h000};
      end
    endcase
    dac_before = dac_all;
    @(negedge clk);
    frame_start = 1'b1;
    twos_comp   = tc;
    cal_mode    = cm;
    @(negedge clk);
    frame_start = 1'b0;
    k = 0;
    while (busy !== 1'b0 && k < 2000) begin
      @(negedge clk);
      k++;
      check(ld_a, ld_b);
      if (rb_valid === 1'b1) begin
        if (q.size() == 0) begin
          check(dac_all, dac_before);
          // A second start while busy must be ignored
          frame_start = 1'b1;
        end
        q.push_back(rb_data);
      end else
        frame_start = 1'b0;
    end
    check(k < 2000, 1'b1);
    check(dac_all, {far, near});
    check(q.size() == 2, 1'b1);
    // Tail is sampled after each rise, so the first old bit is already gone
    // and each word ends with the first bit of the word behind it
    check(q[0], {old_far[WORD_W-2:0], old_near[WORD_W-1]});
    check(q[1], {old_near[WORD_W-2:0], far[WORD_W-1]});
    old_far  = far;
    old_near = near;
  endtask : run_frame

  task automatic t_clear();
    logic [N-1:0] sr_before;
    int           lo;
    sr_before = sr_all;
    @(negedge clk);
    clear_start = 1'b1;
    @(negedge clk);
    clear_start = 1'b0;
    lo = 0;
    while (busy !== 1'b0 && lo < 100) begin
      if (zero_n === 1'b0)
        lo++;
      @(negedge clk);
    end
    check(lo == CLEAR_CYC, 1'b1);
    check(dac_all, '0);
    check(sr_all, sr_before);
  endtask : t_clear

  // ==========================================================
  // Main sequence
  initial begin
    reset_n     = 1'b0;
    in_valid    = 1'b0;
    in_data     = 12'h000;
    frame_start = 1'b0;
    clear_start = 1'b0;
    twos_comp   = 1'b0;
    cal_mode    = CAL_OFF;
    old_far     = 12'h000;
    old_near    = 12'h000;
    n_errors    = 0;
    compares    = 0;
    cycles      = 0;
    repeat (16) @(negedge clk);
    t_reset();
    reset_n = 1'b1;
    t_fill();
    run_frame(1'b0, CAL_OFF);
    run_frame(1'b0, CAL_MID);
    t_clear();
    run_frame(1'b0, CAL_FULL);
    run_frame(1'b0, 2'h3);
    run_frame(1'b1, CAL_OFF);
    run_frame(1'b0, CAL_OFF);
    check(in_ready, 1'b1);
    give_verdict();
  end
endmodule : tb_top
